//--- core/dsau_pkg.sv
// Constants and codes shared by the data-space access unit and its cost helper.
// Assumes one core clock, synchronous active-low reset, requests from the address generators.
package dsau_pkg;
	localparam int EA_W    = 16;
	localparam int DATA_W  = 16;
	localparam int PROG_W  = 24;
	localparam int PAGE_W  = 8;
	localparam int WOFS_W  = 15;
	localparam int WADDR_W = 15;

	// Fixed memory map, not reachable by software
	localparam logic [EA_W-1:0] Y_FIRST  = 16'h1800;
	localparam logic [EA_W-1:0] Y_LAST   = 16'h27FF;
	localparam logic [EA_W-1:0] RAM_LAST = 16'h27FF;

	// Address generator pointer codes
	localparam logic [2:0] PTR_OTHER = 3'h0;
	localparam logic [2:0] PTR_XA    = 3'h1;
	localparam logic [2:0] PTR_XB    = 3'h2;
	localparam logic [2:0] PTR_YA    = 3'h3;
	localparam logic [2:0] PTR_YB    = 3'h4;

	localparam logic [EA_W-1:0] STEP_BYTE = 16'h0001;
	localparam logic [EA_W-1:0] STEP_WORD = 16'h0002;

	// Extra instruction cycles for window accesses
	localparam logic [1:0] EXTRA_NONE = 2'h0;
	localparam logic [1:0] EXTRA_ONE  = 2'h1;
	localparam logic [1:0] EXTRA_TWO  = 2'h2;

	localparam logic [1:0] BE_LOW  = 2'h1;
	localparam logic [1:0] BE_HIGH = 2'h2;
	localparam logic [1:0] BE_WORD = 2'h3;
	localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
endpackage

//--- core/cost_if.sv
// Carrier between the access unit and its window cost helper.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface cost_if;
	logic       redirected;
	logic       fast_kind;
	logic       in_repeat;
	logic       repeat_edge;
	logic [1:0] extra;

	modport calc (input redirected, input fast_kind, input in_repeat, input repeat_edge, output extra);
	modport user (output redirected, output fast_kind, output in_repeat, output repeat_edge, input extra);
endinterface

//--- core/window_cost.sv
// Extra cycle count for a data access through the program window.
// Assumes the sequencer flags repeat edges: first, last, and around interrupts.
`timescale 1ns/1ps
module window_cost
	import dsau_pkg::*;
(
	cost_if.calc c
);
	// Repeat edges refill the two-fetch pipeline; middle iterations hide it
	always_comb
	begin
		if (!c.redirected)
			c.extra = EXTRA_NONE;
		else if (c.in_repeat)
			c.extra = c.repeat_edge ? EXTRA_TWO : EXTRA_NONE;
		else
			c.extra = c.fast_kind ? EXTRA_ONE : EXTRA_TWO;
	end
endmodule // window_cost

//--- core/data_space_access_unit.sv
// Data-space access unit: window into program memory, X/Y routing, byte lanes, alignment traps.
// Assumes data RAM and program memory answer reads in the same cycle as the registered request.
`timescale 1ns/1ps
module data_space_access_unit
	import dsau_pkg::*;
(
	input  wire logic                          i_mclk,
	input  wire logic                          i_rst_n,
	input  wire logic                          i_window_enable,
	input  wire logic [dsau_pkg::PAGE_W-1:0]   i_window_page,
	input  wire logic                          i_table_busy,
	input  wire logic                          i_mac_class,
	input  wire logic                          i_fast_kind,
	input  wire logic                          i_in_repeat,
	input  wire logic                          i_repeat_edge,
	input  wire logic                          i_x_valid,
	input  wire logic                          i_x_write,
	input  wire logic                          i_x_byte,
	input  wire logic [dsau_pkg::EA_W-1:0]     i_x_ea,
	input  wire logic [2:0]                    i_x_ptr,
	input  wire logic                          i_x_bitrev,
	input  wire logic [dsau_pkg::DATA_W-1:0]   i_x_wdata,
	input  wire logic [dsau_pkg::DATA_W-1:0]   i_wreg_old,
	input  wire logic                          i_y_valid,
	input  wire logic [dsau_pkg::EA_W-1:0]     i_y_ea,
	input  wire logic [2:0]                    i_y_ptr,
	input  wire logic [dsau_pkg::DATA_W-1:0]   i_ram_rdata,
	input  wire logic [dsau_pkg::DATA_W-1:0]   i_y_rdata,
	input  wire logic [dsau_pkg::PROG_W-1:0]   i_prog_rdata,
	output logic [dsau_pkg::WADDR_W-1:0]       o_ram_addr,
	output logic                               o_ram_rd,
	output logic                               o_ram_wr,
	output logic [1:0]                         o_ram_be,
	output logic [dsau_pkg::DATA_W-1:0]        o_ram_wdata,
	output logic [dsau_pkg::WADDR_W-1:0]       o_y_addr,
	output logic                               o_y_rd,
	output logic [dsau_pkg::PROG_W-1:0]        o_prog_addr,
	output logic                               o_prog_rd,
	output logic [dsau_pkg::DATA_W-1:0]        o_x_rdata,
	output logic                               o_x_rvalid,
	output logic [dsau_pkg::DATA_W-1:0]        o_wreg_wdata,
	output logic [dsau_pkg::DATA_W-1:0]        o_y_rdata,
	output logic                               o_y_rvalid,
	output logic [dsau_pkg::EA_W-1:0]          o_ea_next,
	output logic                               o_addr_error,
	output logic                               o_mode_fault,
	output logic [1:0]                         o_extra_cycles,
	output logic                               o_stall
);
	import dsau_pkg::*;

	typedef struct packed {
		logic [WADDR_W-1:0] ram_addr;
		logic               ram_rd;
		logic               ram_wr;
		logic [1:0]         ram_be;
		logic [DATA_W-1:0]  ram_wdata;
		logic [WADDR_W-1:0] y_addr;
		logic               y_rd;
		logic [PROG_W-1:0]  prog_addr;
		logic               prog_rd;
		logic               x_pend;
		logic               x_zero;
		logic               x_prog;
		logic               x_byte;
		logic               x_hi;
		logic [7:0]         wreg_hi;
		logic               y_pend;
		logic               y_zero;
		logic [DATA_W-1:0]  x_rdata;
		logic               x_rvalid;
		logic [DATA_W-1:0]  wreg_wdata;
		logic [DATA_W-1:0]  y_rdata;
		logic               y_rvalid;
		logic [EA_W-1:0]    ea_next;
		logic               addr_err;
		logic               mode_fault;
		logic [1:0]         extra;
		logic [1:0]         stall_cnt;
		logic               stall;
	} state_t;

	state_t             st_ff;
	state_t             nxt_st;
	cost_if             cost ();

	logic               x_in_y;
	logic               x_in_ram;
	logic               win_hit;
	logic               x_ptr_ok;
	logic               x_rd;
	logic               x_redir;
	logic               x_rd_ok;
	logic               x_odd;
	logic               x_wr_ok;
	logic               y_in_y;
	logic               y_ptr_ok;
	logic               y_ok;
	logic [EA_W-1:0]    x_step;
	logic [DATA_W-1:0]  x_word;
	logic [7:0]         x_sel;

	// Address decode against the fixed X/Y boundary
	assign x_in_y   = (i_x_ea >= Y_FIRST) && (i_x_ea <= Y_LAST);
	assign x_in_ram = (i_x_ea <= RAM_LAST);
	assign win_hit  = i_x_ea[EA_W-1] & i_window_enable & ~i_table_busy;
	assign x_ptr_ok = (i_x_ptr == PTR_XA) || (i_x_ptr == PTR_XB);
	assign x_rd     = i_x_valid & ~i_x_write;
	assign x_redir  = x_rd & win_hit & (~i_mac_class | x_ptr_ok);
	// Multiply-accumulate X reads lose the Y block; others see it all
	assign x_rd_ok  = i_mac_class ? (x_ptr_ok & ~x_in_y & x_in_ram) : x_in_ram;
	assign x_odd    = ~i_x_byte & i_x_ea[0];
	// Writes reach any implemented address, Y block included
	assign x_wr_ok  = i_x_valid & i_x_write & x_in_ram & ~x_odd;
	assign y_in_y   = (i_y_ea >= Y_FIRST) && (i_y_ea <= Y_LAST);
	assign y_ptr_ok = (i_y_ptr == PTR_YA) || (i_y_ptr == PTR_YB);
	assign y_ok     = y_ptr_ok & y_in_y;
	// DSP word operations never take the byte step
	assign x_step   = (i_x_byte & ~i_mac_class) ? STEP_BYTE : STEP_WORD;

	// Returned word: program low half or RAM, zeroed on invalid access
	assign x_word = st_ff.x_zero ? ZERO_WORD : (st_ff.x_prog ? i_prog_rdata[DATA_W-1:0] : i_ram_rdata);
	assign x_sel  = st_ff.x_hi ? x_word[15:8] : x_word[7:0];

	// Cost helper sees this cycle's window hit
	assign cost.redirected  = x_redir;
	assign cost.fast_kind   = i_fast_kind;
	assign cost.in_repeat   = i_in_repeat;
	assign cost.repeat_edge = i_repeat_edge;

	window_cost u_cost (
		.c (cost.calc)
	);

	// Next state: request stage, then answer stage one edge later
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.ram_rd  = x_rd & ~x_redir & x_rd_ok;
		nxt_st.ram_wr  = x_wr_ok;
		nxt_st.prog_rd = x_redir;
		nxt_st.y_rd    = i_y_valid & y_ok;
		if (i_x_valid)
		begin
			nxt_st.ram_addr  = i_x_ea[EA_W-1:1];
			nxt_st.ram_be    = i_x_byte ? (i_x_ea[0] ? BE_HIGH : BE_LOW) : BE_WORD;
			nxt_st.ram_wdata = i_x_byte ? {i_x_wdata[7:0], i_x_wdata[7:0]} : i_x_wdata;
			nxt_st.ea_next   = i_x_ea + x_step;
		end
		if (x_redir)
			nxt_st.prog_addr = {1'b0, i_window_page, i_x_ea[WOFS_W-1:0]};
		if (i_y_valid)
			nxt_st.y_addr = i_y_ea[EA_W-1:1];
		// Tags follow the read to the answer stage
		nxt_st.x_pend  = x_rd;
		nxt_st.x_zero  = ~(x_redir | x_rd_ok);
		nxt_st.x_prog  = x_redir;
		nxt_st.x_byte  = i_x_byte;
		nxt_st.x_hi    = i_x_ea[0];
		nxt_st.wreg_hi = i_wreg_old[15:8];
		nxt_st.y_pend  = i_y_valid;
		nxt_st.y_zero  = ~y_ok;
		// Answer stage
		nxt_st.x_rvalid = st_ff.x_pend;
		if (st_ff.x_pend)
		begin
			nxt_st.x_rdata    = st_ff.x_byte ? {8'h00, x_sel} : x_word;
			nxt_st.wreg_wdata = st_ff.x_byte ? {st_ff.wreg_hi, x_sel} : x_word;
		end
		// Y answers whole words only
		nxt_st.y_rvalid = st_ff.y_pend;
		if (st_ff.y_pend)
			nxt_st.y_rdata = st_ff.y_zero ? ZERO_WORD : i_y_rdata;
		nxt_st.addr_err   = i_x_valid & x_odd;
		// Bit reversal is only legal on X writes; modulo is never refused
		nxt_st.mode_fault = i_x_valid & i_x_bitrev & ~i_x_write;
		// Stall counter carries the extra window cycles
		if (x_redir)
		begin
			nxt_st.extra     = cost.extra;
			nxt_st.stall_cnt = cost.extra;
		end
		else
		begin
			nxt_st.extra     = EXTRA_NONE;
			nxt_st.stall_cnt = (st_ff.stall_cnt != 2'h0) ? st_ff.stall_cnt - 2'h1 : 2'h0;
		end
		nxt_st.stall = (nxt_st.stall_cnt != 2'h0);
	end

	// State register, cleared by reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register
	assign o_ram_addr     = st_ff.ram_addr;
	assign o_ram_rd       = st_ff.ram_rd;
	assign o_ram_wr       = st_ff.ram_wr;
	assign o_ram_be       = st_ff.ram_be;
	assign o_ram_wdata    = st_ff.ram_wdata;
	assign o_y_addr       = st_ff.y_addr;
	assign o_y_rd         = st_ff.y_rd;
	assign o_prog_addr    = st_ff.prog_addr;
	assign o_prog_rd      = st_ff.prog_rd;
	assign o_x_rdata      = st_ff.x_rdata;
	assign o_x_rvalid     = st_ff.x_rvalid;
	assign o_wreg_wdata   = st_ff.wreg_wdata;
	assign o_y_rdata      = st_ff.y_rdata;
	assign o_y_rvalid     = st_ff.y_rvalid;
	assign o_ea_next      = st_ff.ea_next;
	assign o_addr_error   = st_ff.addr_err;
	assign o_mode_fault   = st_ff.mode_fault;
	assign o_extra_cycles = st_ff.extra;
	assign o_stall        = st_ff.stall;

	// Window address built from page and low offset, top bit clear
	chk_window_address: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && !i_x_write && i_x_ea[15] && i_window_enable && !i_table_busy && !i_mac_class)
		|=> (o_prog_rd && o_prog_addr == {1'b0, $past(i_window_page), $past(i_x_ea[14:0])}))
		else $error("window program address wrong");

	// Table operations hold the window shut
	chk_table_blocks: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_table_busy |=> !o_prog_rd)
		else $error("window used during table access");

	// Redirected word read returns the low program half
	chk_prog_low_word: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(o_prog_rd && !st_ff.x_byte) |=> (o_x_rvalid && o_x_rdata == $past(i_prog_rdata[15:0])))
		else $error("window data not low program half");

	// Byte write strobes one lane
	chk_byte_strobe: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && i_x_write && i_x_byte && i_x_ea <= RAM_LAST)
		|=> (o_ram_wr && o_ram_be == ($past(i_x_ea[0]) ? BE_HIGH : BE_LOW)))
		else $error("byte write lane wrong");

	// Odd word write traps and never reaches memory
	chk_odd_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && i_x_write && !i_x_byte && i_x_ea[0]) |=> (o_addr_error && !o_ram_wr))
		else $error("misaligned write not trapped");

	// Y pointer outside Y block reads zero two cycles on
	chk_y_cross_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_y_valid && (i_y_ea < Y_FIRST || i_y_ea > Y_LAST)) |-> ##2 (o_y_rvalid && o_y_rdata == 16'h0000))
		else $error("cross-space Y read not zero");

	// Multiply-accumulate X read into Y block reads zero
	chk_mac_x_in_y: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && !i_x_write && i_mac_class && i_x_ea >= Y_FIRST && i_x_ea <= Y_LAST)
		|-> ##2 (o_x_rvalid && o_x_rdata == 16'h0000))
		else $error("X read into Y block not zero");

	// Post step of one for bytes outside the multiply-accumulate class, two otherwise
	chk_step_size: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_x_valid |=> (o_ea_next == $past(i_x_ea) + (($past(i_x_byte) && !$past(i_mac_class)) ? 16'h0001 : 16'h0002)))
		else $error("address step wrong");

	// Slow window access outside a repeat stalls exactly two cycles
	chk_stall_two: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(x_redir && !i_fast_kind && !i_in_repeat) ##1 !x_redir[*2] |-> ($past(o_stall) && o_stall) ##1 !o_stall)
		else $error("two-cycle window stall wrong");

	// Fast window access outside a repeat stalls one cycle
	chk_stall_one: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(x_redir && i_fast_kind && !i_in_repeat) ##1 !x_redir |-> (o_stall && o_extra_cycles == 2'h1) ##1 !o_stall)
		else $error("one-cycle window stall wrong");

	// Middle repeat iterations run without extra cycles
	chk_repeat_mid: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(x_redir && i_in_repeat && !i_repeat_edge) |=> (!o_stall && o_extra_cycles == 2'h0))
		else $error("middle repeat iteration stalled");

	// Byte load keeps the register high byte
	chk_byte_merge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(x_rd && i_x_byte) |-> ##2 (o_wreg_wdata[15:8] == $past(i_wreg_old[15:8], 2)))
		else $error("byte load changed high byte");

	// Window stays shut unless top bit and enable are both present
	chk_window_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!(i_x_valid && i_x_ea[15] && i_window_enable) |=> !o_prog_rd)
		else $error("program fetch without window hit");

	// Disabled window: top-half read touches no memory and returns zero
	chk_window_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && !i_x_write && i_x_ea[15] && !i_window_enable)
		|-> ##1 (!o_prog_rd && !o_ram_rd) ##1 (o_x_rvalid && o_x_rdata == 16'h0000))
		else $error("disabled window read not zero");

	// Aligned word write strobes both lanes at the word address
	chk_word_strobe: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && i_x_write && !i_x_byte && !i_x_ea[0] && i_x_ea <= RAM_LAST)
		|=> (o_ram_wr && o_ram_be == BE_WORD && o_ram_addr == $past(i_x_ea[15:1])))
		else $error("word write strobe wrong");

	// Every memory write comes from an X write request
	chk_write_source: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_ram_wr |-> $past(i_x_valid && i_x_write))
		else $error("write without X write request");

	// Unimplemented address below the window reads zero
	chk_unimpl_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && !i_x_write && !i_mac_class && i_x_ea > RAM_LAST && !i_x_ea[15])
		|-> ##2 (o_x_rvalid && o_x_rdata == 16'h0000))
		else $error("unimplemented read not zero");

	// Multiply-accumulate X read through a non-X pointer fetches nothing
	chk_mac_x_ptr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_x_valid && !i_x_write && i_mac_class && i_x_ptr != PTR_XA && i_x_ptr != PTR_XB)
		|=> (!o_ram_rd && !o_prog_rd))
		else $error("X pointer rule broken");

	// Y path hands the fetched word over whole
	chk_y_whole_word: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_y_rd |=> (o_y_rvalid && o_y_rdata == $past(i_y_rdata)))
		else $error("Y word not passed whole");

	// Byte read lands on the low byte with the high byte clear
	chk_byte_low_lane: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(x_rd && i_x_byte) |-> ##2 (o_x_rvalid && o_x_rdata[15:8] == 8'h00))
		else $error("byte read not on low lane");

	// Odd word read traps but still completes
	chk_odd_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(x_rd && !i_x_byte && i_x_ea[0]) |=> o_addr_error ##1 o_x_rvalid)
		else $error("misaligned read not trapped");

	// Bit reversal flagged on reads only
	chk_bitrev_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_x_valid |=> (o_mode_fault == ($past(i_x_bitrev) && !$past(i_x_write))))
		else $error("bit reversal fault wrong");

	// Accesses outside the window add no cycles
	chk_extra_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!x_redir |=> (o_extra_cycles == 2'h0))
		else $error("extra cycles without window access");

	// Edge repeat iterations stall with two extra cycles
	chk_repeat_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(x_redir && i_in_repeat && i_repeat_edge) |=> (o_stall && o_extra_cycles == 2'h2))
		else $error("edge repeat iteration cost wrong");
endmodule // data_space_access_unit

//--- tb/mem_model.sv
// Behavioural data RAM, Y read port and program memory facing the access unit.
// Assumes reads answer combinationally in the cycle the unit raises its strobe.
`timescale 1ns/1ps
module mem_model
	import dsau_pkg::*;
(
	input  wire logic                          i_mclk,
	input  wire logic [dsau_pkg::WADDR_W-1:0]  i_ram_addr,
	input  wire logic                          i_ram_rd,
	input  wire logic [dsau_pkg::WADDR_W-1:0]  i_y_addr,
	input  wire logic                          i_y_rd,
	input  wire logic [dsau_pkg::PROG_W-1:0]   i_prog_addr,
	input  wire logic                          i_prog_rd,
	output logic [dsau_pkg::DATA_W-1:0]        o_ram_rdata,
	output logic [dsau_pkg::DATA_W-1:0]        o_y_rdata,
	output logic [dsau_pkg::PROG_W-1:0]        o_prog_rdata
);
	logic [23:0] noise_ff = 24'h3C96A5;

	// Idle lines alternate between two patterns each cycle, with only the bits set in 24'hA5A5A5 flipping, so a read without a strobe sees changing data
	always_ff @(posedge i_mclk)
	begin
		noise_ff <= ~noise_ff ^ 24'h5A5A5A;
	end

	// Contents derived from the address; upper program byte is junk the unit must drop
	assign o_ram_rdata  = i_ram_rd ? {1'b1, i_ram_addr} : noise_ff[15:0];
	assign o_y_rdata    = i_y_rd ? ({1'b0, i_y_addr} ^ 16'h3C3C) : noise_ff[23:8];
	assign o_prog_rdata = i_prog_rd ? {8'hE1, i_prog_addr[15:0] ^ 16'h0F0F} : noise_ff;
endmodule // mem_model

//--- tb/data_space_access_unit_tb.sv
// Self-checking bench for the data-space access unit.
// Assumes the memory model answers in the strobe cycle; inputs change on the falling edge.
`timescale 1ns/1ps
module data_space_access_unit_tb;
	import dsau_pkg::*;
	logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_window_enable = 1'b0, i_table_busy = 1'b0, i_mac_class = 1'b0;
	logic        i_fast_kind = 1'b0, i_in_repeat = 1'b0, i_repeat_edge = 1'b0, i_x_valid = 1'b0, i_x_write = 1'b0;
	logic        i_x_byte = 1'b0, i_x_bitrev = 1'b0, i_y_valid = 1'b0, yreq = 1'b0;
	logic [7:0]  i_window_page = 8'h00;
	logic [2:0]  i_x_ptr = 3'h0, i_y_ptr = 3'h0;
	logic [15:0] i_x_ea = 16'h0000, i_x_wdata = 16'h0000, i_wreg_old = 16'h0000, i_y_ea = 16'h0000;
	logic [15:0] i_ram_rdata, i_y_rdata, o_ram_wdata, o_x_rdata, o_wreg_wdata, o_y_rdata, o_ea_next;
	logic [23:0] i_prog_rdata, o_prog_addr, s_pa;
	logic [14:0] o_ram_addr, o_y_addr, s_addr, s_ya;
	logic [1:0]  o_ram_be, o_extra_cycles, s_be, s_ext;
	logic        o_ram_rd, o_ram_wr, o_y_rd, o_prog_rd, o_x_rvalid, o_y_rvalid, o_addr_error, o_mode_fault, o_stall;
	logic        s_rd, s_wr, s_prd, s_yrd, s_err, s_flt, s_stl, r_v, r_yv, r_st;
	logic [15:0] s_wd, s_nx, r_d, r_w, r_yd;
	int          error_cnt = 0, compares = 0, cyc = 0;

	data_space_access_unit dut (.i_mclk, .i_rst_n, .i_window_enable, .i_window_page, .i_table_busy,
		.i_mac_class, .i_fast_kind, .i_in_repeat, .i_repeat_edge, .i_x_valid, .i_x_write, .i_x_byte,
		.i_x_ea, .i_x_ptr, .i_x_bitrev, .i_x_wdata, .i_wreg_old, .i_y_valid, .i_y_ea, .i_y_ptr,
		.i_ram_rdata, .i_y_rdata, .i_prog_rdata, .o_ram_addr, .o_ram_rd, .o_ram_wr, .o_ram_be,
		.o_ram_wdata, .o_y_addr, .o_y_rd, .o_prog_addr, .o_prog_rd, .o_x_rdata, .o_x_rvalid,
		.o_wreg_wdata, .o_y_rdata, .o_y_rvalid, .o_ea_next, .o_addr_error, .o_mode_fault,
		.o_extra_cycles, .o_stall);

	mem_model mem (.i_mclk, .i_ram_addr(o_ram_addr), .i_ram_rd(o_ram_rd), .i_y_addr(o_y_addr),
		.i_y_rd(o_y_rd), .i_prog_addr(o_prog_addr), .i_prog_rd(o_prog_rd), .o_ram_rdata(i_ram_rdata),
		.o_y_rdata(i_y_rdata), .o_prog_rdata(i_prog_rdata));

	// 200 MHz core clock
	always #2.5 i_mclk = ~i_mclk;

	// Hang guard: whole run is under a hundred cycles
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic print_verdict();
	begin
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask

	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
	begin
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	end
	endtask

	// One X request (Y beside it when yreq); strobes taken in cycle 1, results in cycle 2
	task automatic acc(input logic w, input logic b, input logic [15:0] ea, input logic [2:0] p);
	begin
		@(negedge i_mclk);
		{i_x_valid, i_y_valid, i_x_write, i_x_byte, i_x_ea, i_x_ptr} = {1'b1, yreq, w, b, ea, p};
		@(negedge i_mclk);
		{i_x_valid, i_y_valid} = 2'b00;
		{s_rd, s_wr, s_prd, s_yrd, s_err, s_flt, s_stl} = {o_ram_rd, o_ram_wr, o_prog_rd, o_y_rd,
			o_addr_error, o_mode_fault, o_stall};
		{s_addr, s_be, s_wd, s_pa, s_nx, s_ya, s_ext} = {o_ram_addr, o_ram_be, o_ram_wdata, o_prog_addr,
			o_ea_next, o_y_addr, o_extra_cycles};
		@(negedge i_mclk);
		{r_v, r_yv, r_st, r_d, r_w, r_yd} = {o_x_rvalid, o_y_rvalid, o_stall, o_x_rdata, o_wreg_wdata, o_y_rdata};
		// No new request while a window stall is still counting
		while (o_stall)
			@(negedge i_mclk);
	end
	endtask

	// Plain word traffic, byte lanes and misaligned words
	task automatic t_words_bytes();
	begin
		acc(1'b0, 1'b0, 16'h1000, PTR_OTHER);
		chk("word read", {s_rd, s_wr, s_prd, s_err, s_ext, s_addr}, {6'b100000, 15'h0800});
		chk("word step", s_nx, 16'h1002);
		chk("word data", {r_v, r_d, r_w}, {1'b1, 16'h8800, 16'h8800});
		i_wreg_old = 16'hABCD;
		acc(1'b0, 1'b1, 16'h1235, PTR_OTHER);
		chk("byte hi", {s_err, s_nx, r_d, r_w}, {1'b0, 16'h1236, 16'h0089, 16'hAB89});
		acc(1'b0, 1'b1, 16'h1234, PTR_OTHER);
		chk("byte lo", {r_d, r_w}, {16'h001A, 16'hAB1A});
		i_x_wdata = 16'h0077;
		acc(1'b1, 1'b1, 16'h1235, PTR_OTHER);
		chk("byte write hi", {s_wr, s_err, s_be, s_wd}, {2'b10, 2'b10, 16'h7777});
		acc(1'b1, 1'b1, 16'h1234, PTR_OTHER);
		chk("byte write lo", {s_wr, s_be}, 3'b101);
		i_x_wdata = 16'h4321;
		acc(1'b1, 1'b0, 16'h2000, PTR_OTHER);
		chk("word write", {s_wr, s_be, s_wd, s_addr}, {3'b111, 16'h4321, 15'h1000});
		acc(1'b1, 1'b0, 16'h1003, PTR_OTHER);
		chk("odd word write", {s_wr, s_err}, 2'b01);
		acc(1'b0, 1'b0, 16'h1005, PTR_OTHER);
		chk("odd word read", {s_rd, s_err, s_addr, r_v, r_d}, {2'b11, 15'h0802, 1'b1, 16'h8802});
		acc(1'b0, 1'b0, 16'h3000, PTR_OTHER);
		chk("unimplemented", {s_rd, r_v, r_d}, {2'b01, 16'h0000});
		i_x_bitrev = 1'b1;
		acc(1'b1, 1'b0, 16'h1000, PTR_OTHER);
		chk("bitrev write", {s_wr, s_flt}, 2'b10);
		acc(1'b0, 1'b0, 16'h1000, PTR_OTHER);
		chk("bitrev read", s_flt, 1'b1);
		i_x_bitrev = 1'b0;
	end
	endtask

	// Window fetch, cost table, blocking by table operations and by the enable
	task automatic t_window();
		logic [2:0] mode [4] = '{3'b100, 3'b000, 3'b011, 3'b010};
		logic [1:0] ext [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
	begin
		i_window_enable = 1'b1;
		i_window_page = 8'h5A;
		for (int k = 0; k < 4; k++)
		begin
			{i_fast_kind, i_in_repeat, i_repeat_edge} = mode[k];
			acc(1'b0, 1'b0, 16'hFFFE, PTR_OTHER);
			chk("window fetch", {s_rd, s_prd, s_pa}, {2'b01, 24'h2D7FFE});
			chk("window data", {r_v, r_d}, {1'b1, 16'h70F1});
			chk("window cost", s_ext, ext[k]);
			chk("window stall", {s_stl, r_st}, {ext[k] != 2'h0, ext[k] == 2'h2});
		end
		{i_fast_kind, i_in_repeat, i_repeat_edge} = 3'b000;
		acc(1'b1, 1'b0, 16'h8004, PTR_OTHER);
		chk("window write", {s_wr, s_prd}, 2'b00);
		i_table_busy = 1'b1;
		acc(1'b0, 1'b0, 16'h8004, PTR_OTHER);
		chk("table blocks", {s_rd, s_prd, r_v, r_d}, {3'b001, 16'h0000});
		{i_table_busy, i_window_enable} = 2'b00;
		acc(1'b0, 1'b0, 16'h8004, PTR_OTHER);
		chk("window off", {s_rd, s_prd, r_v, r_d}, {3'b001, 16'h0000});
	end
	endtask

	// Dual reads of the multiply-accumulate class and pointer-space checks
	task automatic t_mac();
	begin
		{i_mac_class, yreq, i_y_ea, i_y_ptr} = {2'b11, 16'h1800, PTR_YA};
		acc(1'b0, 1'b0, 16'h1800, PTR_XA);
		chk("mac x into y", {s_rd, r_v, r_d}, {2'b01, 16'h0000});
		chk("mac y read", {s_yrd, s_ya, r_yv, r_yd}, {1'b1, 15'h0C00, 1'b1, 16'h303C});
		i_y_ptr = PTR_XA;
		acc(1'b0, 1'b0, 16'h1000, PTR_XB);
		chk("mac x read", {s_rd, r_d}, {1'b1, 16'h8800});
		chk("mac y by x ptr", {s_yrd, r_yv, r_yd}, {2'b01, 16'h0000});
		{i_y_ea, i_y_ptr} = {16'h1000, PTR_YB};
		acc(1'b0, 1'b0, 16'h1000, PTR_YA);
		chk("mac cross", {s_rd, s_yrd, r_d, r_yd}, 40'h0);
		{i_mac_class, yreq} = 2'b00;
		acc(1'b0, 1'b0, 16'h1800, PTR_OTHER);
		chk("composite read", {s_rd, r_d}, {1'b1, 16'h8C00});
	end
	endtask

	initial
	begin
		repeat (6) @(negedge i_mclk);
		i_rst_n = 1'b1;
		t_words_bytes();
		t_window();
		t_mac();
		print_verdict();
	end
endmodule // data_space_access_unit_tb
